// File: occ_map.svh
/*
  Constants for the operator console: panel input bit positions, word and
  address fields, and the register-bus offsets and status bit positions.
  Assumes it is included by occ_pkg.sv, occ_console.sv, the checker and the testbench.
*/
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH

// word, address and instruction fields
`define OCC_W_WORD     24
`define OCC_W_ADDR     15
`define OCC_W_IR       9
`define OCC_IR_MSB     8
`define OCC_ADDR_LSB   9
`define OCC_ADDR_MSB   23
`define OCC_WORD_ZERO  24'h00_0000

// panel control inputs (1 = lever in that position / button pressed)
`define OCC_CB_IR_UP     0
`define OCC_CB_IR_DN     1
`define OCC_CB_RL_UP     2
`define OCC_CB_RL_DN     3
`define OCC_CB_TCLR_DN   4
`define OCC_CB_MODE_UP   5
`define OCC_CB_START     6
`define OCC_CB_HALT      7
`define OCC_CB_MCLR      8
`define OCC_CB_STEP_UP   9
`define OCC_CB_STEP_DN   10
`define OCC_CB_MEM_UP    11
`define OCC_CB_SINGLE    12
`define OCC_CB_RELEASE   13
`define OCC_CB_PAR_UP    14
`define OCC_CB_PAR_RST   15
`define OCC_CB_INHIBIT   16
`define OCC_CB_S1_UP     17
`define OCC_CB_S1_DN     18
`define OCC_CB_S2_UP     19
`define OCC_CB_S2_DN     20
`define OCC_CB_BANK2     21
`define OCC_CB_PC_UP     22
`define OCC_CB_PC_DN     23
`define OCC_NCTL         24
`define OCC_NIN          48

// register bus byte offsets
`define OCC_ADR_STATUS   5'h00
`define OCC_ADR_DISPLAY  5'h04
`define OCC_ADR_ADDR     5'h08
`define OCC_ADR_SENSE    5'h0C
`define OCC_ADR_CTRL     5'h10
`define OCC_CTRL_HALT    0

// status register bit positions
`define OCC_ST_HALT      0
`define OCC_ST_WAIT      1
`define OCC_ST_PERR      2
`define OCC_ST_IRQ       3
`define OCC_ST_OVF       4
`define OCC_ST_INHIBIT   5
`define OCC_ST_BUSY      6

`endif

// File: occ_pkg.sv
/*
  Types for the operator console: register pick, run mode, execution
  handshake state and the packed state of the console module.
  Assumes occ_map.svh is reachable by its bare name.
*/
`include "occ_map.svh"

package occ_pkg;

  typedef enum logic [2:0] {PICK_T, PICK_A, PICK_B, PICK_X1, PICK_X2, PICK_X3} occ_pick_t;
  typedef enum logic [1:0] {RUN_NONE, RUN_CONT, RUN_STEP, RUN_REPEAT} occ_run_t;
  typedef enum logic {EXEC_IDLE, EXEC_BUSY} occ_exec_t;

  typedef struct packed {
    logic [`OCC_NIN-1:0]    sync1;
    logic [`OCC_NIN-1:0]    sync2;
    logic [`OCC_NIN-1:0]    sync3;
    logic [`OCC_NIN-1:0]    stable;
    logic [`OCC_NIN-1:0]    prev;
    logic [`OCC_W_WORD-1:0] t;
    logic [`OCC_W_WORD-1:0] a;
    logic [`OCC_W_WORD-1:0] b;
    logic [`OCC_W_ADDR-1:0] x1;
    logic [`OCC_W_ADDR-1:0] x2;
    logic [`OCC_W_ADDR-1:0] x3;
    logic [`OCC_W_IR-1:0]   ir;
    logic [`OCC_W_ADDR-1:0] pc;
    occ_run_t               run;
    occ_exec_t              exec;
    logic                   exec_go;
    logic                   exec_advance;
    logic                   io_release;
    logic                   mem_req;
    logic                   mem_we;
    logic                   perr;
    logic                   lamp_wait;
    logic                   lamp_irq;
    logic                   lamp_ovf;
    logic                   lamp_halt;
    logic                   irq_inhibit;
    logic [`OCC_W_WORD-1:0] display;
    logic [`OCC_W_WORD-1:0] sense;
    logic                   wb_ack;
    logic [31:0]            wb_dat;
  } occ_state_t;

endpackage

// File: occ_console.sv
/*
  Operator console control for a 24-bit core-memory processor: panel levers,
  buttons and word switches load, clear and display the main registers
  through the holding register, start, halt, step and repeat instructions,
  and run single memory cycles. Lamps and a small register-bus view follow.
  Assumes panel inputs are asynchronous, the processor and memory handshakes
  run on clk_sys, and the bus master is classic Wishbone.
*/
// The register offsets and register access over Wishbone were decided locally.
// How it works
// - instruction lever up copies holding bits 0..8 into instruction register
// - instruction lever down clears the instruction register
// - upper load lever up loads picked register from holding; down clears it
// - lower load lever down clears the holding register
// - mode lever: up gives 24 sense bits, down halts on address match
// - each word switch pressed down sets its holding register bit
// - start button begins execution at the current instruction address
// - halt button stops execution
// - master clear resets all major registers and control latches
// - step lever up repeats current instruction without advancing address
// - step lever down runs one instruction, advances address, then stops
// - memory lever up: single cycle writes holding word to memory
// - memory lever down: single cycle reads memory word into holding
// - wait lamp shows io wait; release button ends the wait
// - parity lever up continues, centered halts; lamp lights either way
// - parity reset lever clears the latched parity error and lamp
// - inhibit holds off interrupts; lamps show interrupt, overflow, halt
// - first selector: up low accumulator, center holding, down index three
// - second selector: up index one, center main accumulator, down index two
// - address lever up loads holding bits 9..23; address always displayed
// - address lever down clears the instruction address counter
// - while running only sense, match, display, halt, release, inhibit, parity lever and master clear controls act
// - instruction address counter is fifteen bits and increments
// - every word read from memory lands in the holding register
`timescale 1ns/1ps
`default_nettype none
`include "occ_map.svh"

module occ_console
  import occ_pkg::*;
#(
  parameter int ADR_W = 5
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  // panel levers and buttons
  input  wire logic [`OCC_NCTL-1:0]   panel_ctl,
  input  wire logic [`OCC_W_WORD-1:0] word_switch_down,
  // panel lamps and displays
  output var  logic [`OCC_W_WORD-1:0] display,
  output var  logic [`OCC_W_ADDR-1:0] instruction_address_counter,
  output var  logic                   lamp_wait,
  output var  logic                   lamp_parity,
  output var  logic                   lamp_irq,
  output var  logic                   lamp_overflow,
  output var  logic                   lamp_halt,
  // processor handshake
  output var  logic                   cpu_exec,
  output var  logic                   cpu_advance,
  input  wire logic                   cpu_done,
  output var  logic [`OCC_W_IR-1:0]   cpu_ir,
  output var  logic [`OCC_W_WORD-1:0] cpu_sense,
  output var  logic                   cpu_irq_inhibit,
  input  wire logic                   cpu_io_wait,
  output var  logic                   cpu_io_release,
  input  wire logic                   cpu_overflow,
  input  wire logic                   irq_pending,
  input  wire logic                   cpu_word_valid,
  input  wire logic [`OCC_W_WORD-1:0] cpu_word,
  input  wire logic                   cpu_word_perr,
  // console memory cycle
  output var  logic                   mem_req,
  output var  logic                   mem_we,
  output var  logic [`OCC_W_ADDR-1:0] mem_addr,
  output var  logic [`OCC_W_WORD-1:0] mem_wdata,
  input  wire logic                   mem_ack,
  input  wire logic [`OCC_W_WORD-1:0] mem_rdata,
  input  wire logic                   mem_perr,
  // register bus
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [ADR_W-1:0]       wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output var  logic [31:0]            wb_dat_o,
  output var  logic                   wb_ack_o
);

  occ_state_t s;
  occ_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic occ_pick_t pick_of(input logic [`OCC_NIN-1:0] lv);
    occ_pick_t p;
    p = PICK_A;

    if (!lv[`OCC_CB_BANK2]) begin
      if (lv[`OCC_CB_S1_UP])      p = PICK_B;
      else if (lv[`OCC_CB_S1_DN]) p = PICK_X3;
      else                        p = PICK_T;
    end else begin
      if (lv[`OCC_CB_S2_UP])      p = PICK_X1;
      else if (lv[`OCC_CB_S2_DN]) p = PICK_X2;
    end
    return p;
  endfunction

  function automatic logic [`OCC_W_WORD-1:0] addr_word(input logic [`OCC_W_ADDR-1:0] v);
    logic [`OCC_W_WORD-1:0] w;

    w = `OCC_WORD_ZERO;
    w[`OCC_ADDR_MSB:`OCC_ADDR_LSB] = v;
    return w;
  endfunction

  function automatic occ_state_t cleared(input occ_state_t c);
    occ_state_t r;
    r        = '0;

    r.sync1  = c.sync1;
    r.sync2  = c.sync2;
    r.sync3  = c.sync3;
    r.stable = c.stable;
    r.prev   = c.prev;
    r.wb_ack = c.wb_ack;
    r.wb_dat = c.wb_dat;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [`OCC_NIN-1:0]    lvl;
  logic [`OCC_NIN-1:0]    edg;
  logic [`OCC_W_WORD-1:0] sw_up;
  logic [`OCC_W_WORD-1:0] ld_val;
  logic [`OCC_W_ADDR-1:0] pc_after;
  logic                   stopped;
  logic                   match_hit;
  logic                   wb_take;
  logic                   halt_now;

  occ_pick_t              pick;

  always_comb begin
    next_s = s;

    lvl    = s.stable;
    // edge-driven controls act only on a rise of a settled input
    edg    = s.stable & ~s.prev;
    sw_up  = ~lvl[`OCC_NIN-1:`OCC_NCTL];
    pick   = pick_of(lvl);
    ld_val = `OCC_WORD_ZERO;

    // three-stage sync; a bit changes once stages two and three agree
    next_s.sync1  = {word_switch_down, panel_ctl};
    next_s.sync2  = s.sync1;
    next_s.sync3  = s.sync2;
    next_s.stable = (s.sync2 & s.sync3) | (s.stable & (s.sync2 ^ s.sync3));
    next_s.prev   = s.stable;

    stopped           = (s.run == RUN_NONE) && (s.exec == EXEC_IDLE);

    next_s.exec_go    = 1'b0;
    next_s.io_release = 1'b0;

    // bus write of the halt bit acts as a program halt
    wb_take  = wb_cyc_i && wb_stb_i && !s.wb_ack;

    halt_now = edg[`OCC_CB_HALT]
             || (s.perr && !lvl[`OCC_CB_PAR_UP])
             || (wb_take && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == `OCC_ADR_CTRL && wb_dat_i[`OCC_CTRL_HALT]);

    // console operations only while stopped
    if (stopped) begin
      if (edg[`OCC_CB_IR_UP]) next_s.ir = s.t[`OCC_IR_MSB:0];
      if (edg[`OCC_CB_IR_DN]) next_s.ir = '0;

      if (edg[`OCC_CB_PC_UP])
        next_s.pc = s.t[`OCC_ADDR_MSB:`OCC_ADDR_LSB];
      if (edg[`OCC_CB_PC_DN]) next_s.pc = '0;

      if (edg[`OCC_CB_TCLR_DN]) next_s.t = `OCC_WORD_ZERO;
      if (edg[`OCC_CB_RL_UP] || edg[`OCC_CB_RL_DN]) begin
        ld_val = edg[`OCC_CB_RL_UP] ? s.t : `OCC_WORD_ZERO;
        unique case (pick)
          PICK_T:  next_s.t  = ld_val;
          PICK_A:  next_s.a  = ld_val;
          PICK_B:  next_s.b  = ld_val;
          PICK_X1: next_s.x1 = ld_val[`OCC_ADDR_MSB:`OCC_ADDR_LSB];
          PICK_X2: next_s.x2 = ld_val[`OCC_ADDR_MSB:`OCC_ADDR_LSB];
          PICK_X3: next_s.x3 = ld_val[`OCC_ADDR_MSB:`OCC_ADDR_LSB];
        endcase
      end

      // word switch sets land after clears and loads
      next_s.t = next_s.t | edg[`OCC_NIN-1:`OCC_NCTL];

      if (edg[`OCC_CB_PAR_RST]) next_s.perr = 1'b0;

      if (edg[`OCC_CB_SINGLE] && !s.mem_req) begin
        next_s.mem_req = 1'b1;
        next_s.mem_we  = lvl[`OCC_CB_MEM_UP];
      end

      if (edg[`OCC_CB_START]) begin
        next_s.run          = RUN_CONT;
        next_s.exec         = EXEC_BUSY;
        next_s.exec_go      = 1'b1;
        next_s.exec_advance = 1'b1;
      end else if (edg[`OCC_CB_STEP_DN]) begin
        next_s.run          = RUN_STEP;
        next_s.exec         = EXEC_BUSY;
        next_s.exec_go      = 1'b1;
        next_s.exec_advance = 1'b1;
      end else if (edg[`OCC_CB_STEP_UP]) begin
        next_s.run          = RUN_REPEAT;
        next_s.exec         = EXEC_BUSY;
        next_s.exec_go      = 1'b1;
        next_s.exec_advance = 1'b0;
      end
    end

    // read words into the holding register; parity errors latch, set wins
    if (s.mem_req && mem_ack) begin
      next_s.mem_req = 1'b0;
      if (!s.mem_we) begin
        next_s.t = mem_rdata;
        if (mem_perr) next_s.perr = 1'b1;
      end
    end

    if (cpu_word_valid) begin
      next_s.t = cpu_word;
      if (cpu_word_perr) next_s.perr = 1'b1;
    end

    // instruction completion and address-match halt
    pc_after  = (s.run == RUN_REPEAT) ? s.pc : s.pc + `OCC_W_ADDR'(1);
    match_hit = !lvl[`OCC_CB_MODE_UP]
              && (pc_after == sw_up[`OCC_ADDR_MSB:`OCC_ADDR_LSB]);

    if (s.exec == EXEC_BUSY && cpu_done) begin
      next_s.pc = pc_after;
      if (s.run == RUN_CONT && !halt_now && !match_hit) begin
        next_s.exec_go = 1'b1;
      end else begin
        next_s.exec = EXEC_IDLE;
        next_s.run  = RUN_NONE;
      end
    end

    if (halt_now && s.run == RUN_CONT) next_s.run = RUN_NONE;

    if (edg[`OCC_CB_RELEASE] && cpu_io_wait)
      next_s.io_release = 1'b1;

    // lamps and displays
    next_s.lamp_wait   = cpu_io_wait;
    next_s.lamp_irq    = irq_pending;
    next_s.lamp_ovf    = cpu_overflow;

    next_s.irq_inhibit = lvl[`OCC_CB_INHIBIT];
    next_s.sense       = lvl[`OCC_CB_MODE_UP] ? sw_up : `OCC_WORD_ZERO;

    unique case (pick)
      PICK_T:  next_s.display = s.t;
      PICK_A:  next_s.display = s.a;
      PICK_B:  next_s.display = s.b;
      PICK_X1: next_s.display = addr_word(s.x1);
      PICK_X2: next_s.display = addr_word(s.x2);
      PICK_X3: next_s.display = addr_word(s.x3);
    endcase

    // register bus slave: one wait state, unmapped reads give zero
    next_s.wb_ack = wb_take;

    if (wb_take) begin
      next_s.wb_dat = '0;
      if (!wb_we_i) begin
        unique case (wb_adr_i)
          `OCC_ADR_STATUS: begin
            next_s.wb_dat[`OCC_ST_HALT]    = s.lamp_halt;
            next_s.wb_dat[`OCC_ST_WAIT]    = s.lamp_wait;
            next_s.wb_dat[`OCC_ST_PERR]    = s.perr;
            next_s.wb_dat[`OCC_ST_IRQ]     = s.lamp_irq;
            next_s.wb_dat[`OCC_ST_OVF]     = s.lamp_ovf;
            next_s.wb_dat[`OCC_ST_INHIBIT] = s.irq_inhibit;
            next_s.wb_dat[`OCC_ST_BUSY]    = s.exec == EXEC_BUSY;
          end
          `OCC_ADR_DISPLAY: next_s.wb_dat[`OCC_W_WORD-1:0] = s.display;
          `OCC_ADR_ADDR:    next_s.wb_dat[`OCC_W_ADDR-1:0] = s.pc;
          `OCC_ADR_SENSE:   next_s.wb_dat[`OCC_W_WORD-1:0] = s.sense;
          default:          next_s.wb_dat = '0;
        endcase
      end
    end

    // master clear overrides everything but the input sync and bus answer on its edge
    if (edg[`OCC_CB_MCLR]) next_s = cleared(next_s);

    next_s.lamp_halt = (next_s.run == RUN_NONE) && (next_s.exec == EXEC_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from state

  assign display                     = s.display;
  assign instruction_address_counter = s.pc;
  assign lamp_wait                   = s.lamp_wait;
  assign lamp_parity                 = s.perr;
  assign lamp_irq                    = s.lamp_irq;
  assign lamp_overflow               = s.lamp_ovf;
  assign lamp_halt                   = s.lamp_halt;

  assign cpu_exec                    = s.exec_go;
  assign cpu_advance                 = s.exec_advance;
  assign cpu_ir                      = s.ir;
  assign cpu_sense                   = s.sense;
  assign cpu_irq_inhibit             = s.irq_inhibit;
  assign cpu_io_release              = s.io_release;

  assign mem_req                     = s.mem_req;
  assign mem_we                      = s.mem_we;
  assign mem_addr                    = s.pc;
  assign mem_wdata                   = s.t;

  assign wb_dat_o                    = s.wb_dat;
  assign wb_ack_o                    = s.wb_ack;

endmodule

`default_nettype wire

// File: occ_console_sva.sv
/*
  Checker for occ_console: bus answer, execution pulses, counter, memory
  cycle, release pulse and lamps.
  Assumes it is bound to occ_console and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
`include "occ_map.svh"

module occ_console_sva (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // panel and lamps
  input wire logic [23:0] panel_ctl,
  input wire logic        lamp_halt,
  input wire logic        lamp_overflow,
  input wire logic [14:0] instruction_address_counter,
  // processor side
  input wire logic        cpu_exec,
  input wire logic        cpu_advance,
  input wire logic        cpu_done,
  input wire logic        cpu_overflow,
  input wire logic        cpu_io_wait,
  input wire logic        cpu_io_release,
  // memory and bus
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [14:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o
);
  logic       adv_q;
  logic [7:0] mc_hist;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////
  // kind of the instruction in flight; recent master clear presses
  always_ff @(posedge clk_sys) begin
    if (cpu_exec) begin
      adv_q <= cpu_advance;
    end
    mc_hist <= resetn ? {mc_hist[6:0], panel_ctl[`OCC_CB_MCLR]} : 8'h00;
  end

  ////////////////////////////////////////////////////////////////
  property p_bus_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer late or long");
  property p_exec_cause;
    cpu_exec |-> $past(lamp_halt) || $past(cpu_done);
  endproperty
  a_exec_cause: assert property (p_exec_cause) else $error("exec without cause");
  property p_exec_lamp;
    cpu_exec |-> !lamp_halt;
  endproperty
  a_exec_lamp: assert property (p_exec_lamp) else $error("halt lamp lit in exec");
  property p_pc_step;
    cpu_done && adv_q && mc_hist == 8'h00 |=>
      instruction_address_counter == $past(instruction_address_counter) + 15'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("counter did not advance");
  property p_pc_repeat;
    cpu_done && !adv_q |=> $stable(instruction_address_counter);
  endproperty
  a_pc_repeat: assert property (p_pc_repeat) else $error("repeat moved counter");
  property p_run_hold;
    !lamp_halt && !cpu_done && mc_hist == 8'h00 |=> $stable(instruction_address_counter);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("counter moved in run");
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_we) && $stable(mem_addr);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request not held");
  property p_mem_drop;
    mem_ack |=> !mem_req;
  endproperty
  a_mem_drop: assert property (p_mem_drop) else $error("memory request not dropped");
  property p_release;
    cpu_io_release |-> $past(cpu_io_wait) && !$past(cpu_io_release);
  endproperty
  a_release: assert property (p_release) else $error("bad release pulse");
  property p_ovf_lamp;
    $past(resetn) && mc_hist == 8'h00 |-> lamp_overflow == $past(cpu_overflow);
  endproperty
  a_ovf_lamp: assert property (p_ovf_lamp) else $error("overflow lamp wrong");

  c_repeat: cover property (cpu_done && !adv_q);
  c_write: cover property (mem_ack && mem_we);
  c_release: cover property (cpu_io_release);
endmodule

bind occ_console occ_console_sva u_occ_console_sva (
  .clk_sys, .resetn, .panel_ctl, .lamp_halt, .lamp_overflow, .instruction_address_counter,
  .cpu_exec, .cpu_advance, .cpu_done, .cpu_overflow, .cpu_io_wait, .cpu_io_release,
  .mem_req, .mem_we, .mem_addr, .mem_ack, .wb_cyc_i, .wb_stb_i, .wb_ack_o
);
`default_nettype wire

// File: occ_cpu_model.sv
/*
  Processor and core memory model: ends instructions after a short or long
  delay and answers console memory cycles, with parity error on demand.
  Assumes the console clock and its active-low synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module occ_cpu_model (
  // clock, reset and scenario controls
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        slow,
  input  wire logic        perr_inj,
  // execution and memory
  input  wire logic        cpu_exec,
  output var  logic        cpu_done,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [14:0] mem_addr,
  input  wire logic [23:0] mem_wdata,
  output var  logic        mem_ack,
  output var  logic [23:0] mem_rdata,
  output var  logic        mem_perr
);
  logic [23:0] mem [16];
  int          ecnt;
  int          mcnt;

  always_ff @(posedge clk_sys) begin
    cpu_done <= 1'b0;
    mem_ack  <= 1'b0;
    mem_perr <= 1'b0;
    // released read lines never hold the last word
    mem_rdata <= ~mem_rdata;
    if (!resetn) begin
      ecnt      <= 0;
      mcnt      <= 0;
      mem_rdata <= 24'h00_0000;
    end else begin
      if (cpu_exec) begin
        ecnt <= slow ? 6 : 2;
      end else if (ecnt > 0) begin
        ecnt     <= ecnt - 1;
        cpu_done <= (ecnt == 1);
      end
      if (mem_req && !mem_ack) begin
        mcnt <= mcnt + 1;
        if (mcnt >= (slow ? 3 : 0)) begin
          mcnt    <= 0;
          mem_ack <= 1'b1;
          if (mem_we) begin
            mem[mem_addr[3:0]] <= mem_wdata;
          end else begin
            mem_rdata <= mem[mem_addr[3:0]];
            mem_perr  <= perr_inj;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb_occ_console.sv
/*
  Testbench for occ_console: panel presses, bus reads and writes, memory
  cycles through the processor model, checked against expected values.
  Assumes occ_console, occ_cpu_model and the bound checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "occ_map.svh"

module tb_occ_console;
  localparam logic [23:0] TV = 24'h12_3456;
  logic        clk_sys = 1'b0, resetn = 1'b0, slow = 1'b0, perr_inj = 1'b0;
  logic [23:0] panel_ctl = 24'h00_0000, word_switch_down = 24'h00_0000;
  logic        cpu_io_wait = 1'b0, cpu_overflow = 1'b0, irq_pending = 1'b0;
  logic        cpu_word_valid = 1'b0, cpu_word_perr = 1'b0;
  logic [23:0] cpu_word = 24'h00_0000;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic [23:0] display, cpu_sense, mem_wdata, mem_rdata;
  logic [14:0] instruction_address_counter, mem_addr;
  logic [8:0]  cpu_ir;
  logic        lamp_wait, lamp_parity, lamp_irq, lamp_overflow, lamp_halt, cpu_exec;
  logic        cpu_advance, cpu_done, cpu_irq_inhibit, cpu_io_release, mem_req, mem_we;
  logic        mem_ack, mem_perr, wb_ack_o;
  int          n_mismatch = 0, cmp_count = 0, n_rel = 0;
  logic [23:0] pk [6] = '{24'h02_0000, 24'h04_0000, 24'h28_0000, 24'h20_0000,
                          24'h30_0000, 24'h00_0000};

  occ_console #(.ADR_W(5)) u_occ_console (
    .clk_sys, .resetn, .panel_ctl, .word_switch_down, .display, .instruction_address_counter,
    .lamp_wait, .lamp_parity, .lamp_irq, .lamp_overflow, .lamp_halt, .cpu_exec, .cpu_advance,
    .cpu_done, .cpu_ir, .cpu_sense, .cpu_irq_inhibit, .cpu_io_wait, .cpu_io_release,
    .cpu_overflow, .irq_pending, .cpu_word_valid, .cpu_word, .cpu_word_perr, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .mem_perr, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o
  );
  occ_cpu_model u_occ_cpu_model (
    .clk_sys, .resetn, .slow, .perr_inj, .cpu_exec, .cpu_done, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .mem_perr
  );

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) n_rel <= n_rel + (cpu_io_release === 1'b1);

  ////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pnl(input int b, input logic v);
    @(posedge clk_sys);
    panel_ctl[b] <= v;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic press(input int b);
    pnl(b, 1'b1);
    pnl(b, 1'b0);
  endtask
  task automatic sw(input logic [23:0] v);
    @(posedge clk_sys);
    word_switch_down <= v;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic wbx(input logic [4:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hF};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    chk("bus answer", 32'h1, wb_ack_o);
  endtask
  task automatic wait_halt;
    int n;
    n = 0;
    while (lamp_halt !== 1'b1 && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    chk("halt lamp", 32'h1, lamp_halt);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    $display("Error watchdog expired");
    n_mismatch++;
    print_verdict;
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wbx(5'h00, 1'b0, 0); chk("status", 32'h1, q);
    wbx(5'h14, 1'b1, 32'hFFFF_FFFF);
    wbx(5'h14, 1'b0, 0); chk("unmapped", 0, q);
    sw(TV); sw(24'h00_0000); chk("holding", TV, display);
    press(`OCC_CB_IR_UP); chk("ir", TV[8:0], cpu_ir);
    press(`OCC_CB_IR_DN); chk("ir", 0, cpu_ir);
    press(`OCC_CB_PC_UP); chk("counter", TV[23:9], instruction_address_counter);
    // every pick: load from holding, then clear; holding itself last
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      panel_ctl <= pk[i];
      press(`OCC_CB_RL_UP);
      chk("load", (i inside {1, 2, 4}) ? TV & 24'hFF_FE00 : TV, display);
      press(i < 5 ? `OCC_CB_RL_DN : `OCC_CB_TCLR_DN); chk("clear", 0, display);
    end
    sw(TV); sw(24'h00_0000);
    press(`OCC_CB_PC_DN); chk("counter", 0, instruction_address_counter);
    pnl(`OCC_CB_MEM_UP, 1'b1); press(`OCC_CB_SINGLE); pnl(`OCC_CB_MEM_UP, 1'b0);
    press(`OCC_CB_TCLR_DN);
    {slow, perr_inj} <= 2'b11;
    press(`OCC_CB_SINGLE); chk("read", TV, display);
    chk("parity lamp", 1, lamp_parity);
    perr_inj <= 1'b0;
    press(`OCC_CB_PAR_RST); chk("parity lamp", 0, lamp_parity);
    press(`OCC_CB_STEP_DN); chk("step", 1, instruction_address_counter);
    press(`OCC_CB_STEP_UP); chk("repeat", 1, instruction_address_counter);
    wbx(5'h00, 1'b0, 0); chk("stopped", 1, q[0]);
    pnl(`OCC_CB_MODE_UP, 1'b1); sw(24'h0F_0F0F);
    chk("sense", 24'hF0_F0F0, cpu_sense);
    wbx(5'h0C, 1'b0, 0); chk("sense reg", 24'hF0_F0F0, q);
    sw(24'h00_0000); pnl(`OCC_CB_MODE_UP, 1'b0);
    press(`OCC_CB_START); wbx(5'h00, 1'b0, 0); chk("running", 0, q[0]);
    press(`OCC_CB_PC_DN);
    press(`OCC_CB_HALT); wait_halt();
    press(`OCC_CB_START); wbx(5'h10, 1'b1, 32'h0000_0001); wait_halt();
    press(`OCC_CB_PC_DN); sw({~15'd5, 9'h000}); slow <= 1'b0;
    press(`OCC_CB_START); wait_halt();
    chk("match", 5, instruction_address_counter);
    sw(24'h00_0000);
    pnl(`OCC_CB_PAR_UP, 1'b1); press(`OCC_CB_START);
    {cpu_word_valid, cpu_word_perr, cpu_word} <= {2'b11, TV};
    @(posedge clk_sys); cpu_word_valid <= 1'b0; repeat (4) @(posedge clk_sys);
    chk("run on", 0, lamp_halt);
    chk("word", TV, display);
    pnl(`OCC_CB_PAR_UP, 1'b0); wait_halt();
    {cpu_io_wait, cpu_overflow, irq_pending} <= 3'b111;
    pnl(`OCC_CB_INHIBIT, 1'b1);
    chk("wait lamp", 1, lamp_wait);
    chk("inhibit", 1, cpu_irq_inhibit);
    chk("irq lamp", 1, lamp_irq);
    wbx(5'h00, 1'b0, 0); chk("lamps", 32'h3A, q & 32'h3A);
    press(`OCC_CB_RELEASE); chk("release", 1, n_rel);
    cpu_io_wait <= 1'b0;
    press(`OCC_CB_RELEASE); chk("release", 1, n_rel);
    pnl(`OCC_CB_INHIBIT, 1'b0);
    press(`OCC_CB_MCLR); chk("clear counter", 0, instruction_address_counter);
    chk("clear display", 0, display);
    print_verdict;
  end
endmodule
`default_nettype wire
